// file: shared/schc_pkg.sv
package schc_pkg;
   // command codes; OP_START_AUTO stays on the request side, the host sends it on the link as OP_START_RX
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_SET_PROP = 3'h1,
      OP_START_RX = 3'h2,
      OP_START_TX = 3'h3,
      OP_RX_HOP = 3'h4,
      OP_GO_IDLE = 3'h5,
      OP_START_AUTO = 3'h6
   } schc_op_t;

   // sequencer states, gray along idle-settle-listen-search-lock-tx
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETTLE = 3'h1,
      ST_LISTEN = 3'h3,
      ST_SEARCH = 3'h2,
      ST_LOCK = 3'h6,
      ST_TX = 3'h7
   } schc_state_t;

   // property addresses
   localparam logic [7:0] PROP_SYNTH_INTEGER = 8'h00;
   localparam logic [7:0] PROP_SYNTH_FRAC_HIGH = 8'h01;
   localparam logic [7:0] PROP_SYNTH_FRAC_MID = 8'h02;
   localparam logic [7:0] PROP_SYNTH_FRAC_LOW = 8'h03;
   localparam logic [7:0] PROP_STEP_HIGH = 8'h04;
   localparam logic [7:0] PROP_STEP_LOW = 8'h05;
   localparam logic [7:0] PROP_BAND = 8'h06;
   localparam logic [7:0] PROP_HOP_CONTROL = 8'h07;
   localparam logic [7:0] PROP_TABLE_SIZE = 8'h08;
   localparam logic [7:0] PROP_LEVEL_THRESHOLD = 8'h09;
   localparam logic [7:0] PROP_PREAMBLE_DETECT = 8'h0A;
   localparam logic [7:0] PROP_PREAMBLE_TIMEOUT = 8'h0B;
   localparam logic [7:0] PROP_GPIO_CFG = 8'h0C;
   localparam logic [7:0] PROP_TABLE_BASE = 8'h40;

   // hop control field positions
   localparam int HC_AUTO_EN = 0;
   localparam int HC_RSSI_EN = 1;
   localparam int HC_PREAMBLE_EN = 2;
   localparam int HC_SYNC_EN = 3;
   localparam int HC_RAW_MODE = 4;

   // band dividers, lowest band first
   localparam logic [4:0] DIV_BAND0 = 5'h18;
   localparam logic [4:0] DIV_BAND1 = 5'h0C;
   localparam logic [4:0] DIV_BAND2 = 5'h08;
   localparam logic [4:0] DIV_BAND3 = 5'h04;

   localparam logic [7:0] SKIP_ENTRY = 8'hFF;
   localparam logic [7:0] CHAN_RESET = 8'h00;
   localparam int TABLE_MAX = 64;

   // fraction window: high byte holds bits 23:16, value/2^19 in [1,2)
   localparam logic [7:0] FRAC_HIGH_MIN = 8'h08;
   localparam logic [7:0] FRAC_HIGH_MAX = 8'h0F;

   // timing
   localparam int CLK_MHZ = 50;
   localparam int AUTO_HOP_US = 115;
   localparam int MAN_HOP_US = 75;
   localparam int AUTO_HOP_CYC = AUTO_HOP_US * CLK_MHZ;
   localparam int MAN_HOP_CYC = MAN_HOP_US * CLK_MHZ;
endpackage

// file: shared/schc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface schc_if;
   import schc_pkg::*;
   logic cmdValid;
   schc_op_t cmdOp;
   logic [7:0] cmdAddr;
   logic [7:0] cmdData;
   logic [7:0] cmdChan;
   logic cmdHasChan;
   logic [15:0] cmdCalCount;
   logic cmdDone;

   modport dev (
      input cmdValid, cmdOp, cmdAddr, cmdData, cmdChan, cmdHasChan, cmdCalCount,
      output cmdDone
   );
   modport hst (
      output cmdValid, cmdOp, cmdAddr, cmdData, cmdChan, cmdHasChan, cmdCalCount,
      input cmdDone
   );
endinterface
`default_nettype wire

// file: src/schc_device.sv
`timescale 1ns/1ps
`default_nettype none
module schc_device
   import schc_pkg::*;
#(
   parameter int TABLE_DEPTH = TABLE_MAX,
   parameter int AUTO_CYC = AUTO_HOP_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   schc_if.dev link,
   input wire logic [7:0] rssiNow,
   input wire logic preambleBad,
   input wire logic syncMissing,
   output logic [31:0] freqWord_q,
   output logic [4:0] outDiv_q,
   output logic [7:0] curChan_q,
   output logic [15:0] oscCal_q,
   output logic rxOn_q,
   output logic txOn_q,
   output logic locked_q,
   output logic hopGpio_q
);
   localparam int PW = $clog2(TABLE_DEPTH);

   // refuse parameter values the pointer or settle counter cannot serve
   if (TABLE_DEPTH < 2 || TABLE_DEPTH > TABLE_MAX) begin : g_bad_depth
      $error("TABLE_DEPTH out of range");
   end
   if (AUTO_CYC < 1 || AUTO_CYC > 8191) begin : g_bad_cyc
      $error("AUTO_CYC out of range");
   end

   logic [7:0] intSet_q, fracHigh_q, fracMid_q, fracLow_q;
   logic [15:0] step_q;
   logic [1:0] band_q;
   logic [4:0] hopCtl_q;
   logic [6:0] tableSize_q;
   logic [7:0] threshold_q, preDetect_q, preTimeout_q;
   logic gpioCfg_q;
   logic [7:0] hopTable [TABLE_DEPTH];
   schc_state_t state_q;
   logic [PW-1:0] ptr_q;
   logic [6:0] scanned_q;
   logic [12:0] settle_q;
   logic settleRx_q;
   logic autoHop_q;
   logic [7:0] chan_q;
   logic cmdDone_q;

   logic isProp, tblWrite;
   logic [PW-1:0] ptrNext;
   logic wrapNext;
   logic hopNeeded, stayNeeded;
   logic [7:0] newChan;
   logic [31:0] baseWord;

   assign isProp = link.cmdValid && link.cmdOp == OP_SET_PROP;
   assign tblWrite = isProp && link.cmdAddr >= PROP_TABLE_BASE
      && link.cmdAddr < PROP_TABLE_BASE + 8'(TABLE_DEPTH);
   assign link.cmdDone = cmdDone_q;

   // property store
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         intSet_q <= 8'h00;
         fracHigh_q <= FRAC_HIGH_MIN;
         fracMid_q <= 8'h00;
         fracLow_q <= 8'h00;
         step_q <= 16'h0000;
         band_q <= 2'h0;
         hopCtl_q <= 5'h00;
         tableSize_q <= 7'h00;
         threshold_q <= 8'h00;
         preDetect_q <= 8'h00;
         preTimeout_q <= 8'h00;
         gpioCfg_q <= 1'b0;
      end else if (isProp) begin
         case (link.cmdAddr)
            PROP_SYNTH_INTEGER: intSet_q <= link.cmdData;
            PROP_SYNTH_FRAC_HIGH: fracHigh_q <= link.cmdData;
            PROP_SYNTH_FRAC_MID: fracMid_q <= link.cmdData;
            PROP_SYNTH_FRAC_LOW: fracLow_q <= link.cmdData;
            PROP_STEP_HIGH: step_q[15:8] <= link.cmdData;
            PROP_STEP_LOW: step_q[7:0] <= link.cmdData;
            PROP_BAND: band_q <= link.cmdData[1:0];
            PROP_HOP_CONTROL: hopCtl_q <= link.cmdData[4:0];
            PROP_TABLE_SIZE: begin
               if (link.cmdData > 8'(TABLE_DEPTH)) tableSize_q <= 7'(TABLE_DEPTH);
               else tableSize_q <= link.cmdData[6:0];
            end
            PROP_LEVEL_THRESHOLD: threshold_q <= link.cmdData;
            PROP_PREAMBLE_DETECT: preDetect_q <= link.cmdData;
            PROP_PREAMBLE_TIMEOUT: preTimeout_q <= link.cmdData;
            PROP_GPIO_CFG: gpioCfg_q <= link.cmdData[0];
            default: ;
         endcase
      end
   end

   // hop table memory, no reset
   always_ff @(posedge mclk) begin
      if (tblWrite) begin
         hopTable[PW'(link.cmdAddr - PROP_TABLE_BASE)] <= link.cmdData;
      end
   end

   // next pointer with wrap at the last active entry
   always_comb begin
      wrapNext = (7'(ptr_q) + 7'h01 >= tableSize_q);
      ptrNext = wrapNext ? '0 : ptr_q + PW'(1);
   end

   // decision: an enabled RSSI check decides alone, else the first enabled timeout that is met wins; raw mode masks timeouts
   always_comb begin
      stayNeeded = 1'b0;
      hopNeeded = 1'b0;
      if (hopCtl_q[HC_RSSI_EN] && rssiNow > threshold_q) begin
         stayNeeded = 1'b1;
      end else if (hopCtl_q[HC_RSSI_EN]) begin
         hopNeeded = 1'b1;
      end else if (!hopCtl_q[HC_RAW_MODE] && hopCtl_q[HC_PREAMBLE_EN] && preambleBad) begin
         hopNeeded = 1'b1;
      end else if (!hopCtl_q[HC_RAW_MODE] && hopCtl_q[HC_SYNC_EN] && syncMissing) begin
         hopNeeded = 1'b1;
      end
   end

   assign newChan = link.cmdHasChan ? link.cmdChan : chan_q;

   // sequencer
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         ptr_q <= '0;
         scanned_q <= 7'h00;
         settle_q <= 13'h0000;
         settleRx_q <= 1'b0;
         autoHop_q <= 1'b0;
         chan_q <= CHAN_RESET;
         hopGpio_q <= 1'b0;
      end else if (link.cmdValid && (link.cmdOp == OP_START_RX || link.cmdOp == OP_START_TX)) begin
         chan_q <= newChan;
         ptr_q <= '0;
         settle_q <= 13'(AUTO_CYC);
         settleRx_q <= link.cmdOp == OP_START_RX;
         autoHop_q <= 1'b0;
         state_q <= ST_SETTLE;
      end else if (link.cmdValid && link.cmdOp == OP_RX_HOP) begin
         chan_q <= link.cmdChan;
         settle_q <= 13'(MAN_HOP_CYC);
         settleRx_q <= 1'b1;
         autoHop_q <= 1'b0;
         state_q <= ST_SETTLE;
      end else if (link.cmdValid && link.cmdOp == OP_GO_IDLE) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_SETTLE: begin
               if (settle_q > 13'h0001) begin
                  settle_q <= settle_q - 13'h0001;
               end else begin
                  state_q <= settleRx_q ? ST_LISTEN : ST_TX;
                  if (autoHop_q && gpioCfg_q) hopGpio_q <= ~hopGpio_q;
               end
            end
            ST_LISTEN: begin
               if (hopCtl_q[HC_AUTO_EN] && tableSize_q != 7'h00) begin
                  if (stayNeeded) begin
                     state_q <= ST_LOCK;
                  end else if (hopNeeded) begin
                     scanned_q <= 7'h00;
                     state_q <= ST_SEARCH;
                  end
               end
            end
            ST_SEARCH: begin
               ptr_q <= ptrNext;
               scanned_q <= scanned_q + 7'h01;
               if (wrapNext && gpioCfg_q) hopGpio_q <= ~hopGpio_q;
               if (hopTable[ptrNext] != SKIP_ENTRY) begin
                  chan_q <= hopTable[ptrNext];
                  settle_q <= 13'(AUTO_CYC);
                  settleRx_q <= 1'b1;
                  autoHop_q <= 1'b1;
                  state_q <= ST_SETTLE;
               end else if (scanned_q + 7'h01 >= tableSize_q) begin
                  state_q <= ST_LISTEN; // every entry skipped, stay put
               end
            end
            ST_LOCK: ;
            ST_TX: ;
            ST_IDLE: ;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // host supplied calibration count for manual hops
   always_ff @(posedge mclk) begin
      if (!rstn) oscCal_q <= 16'h0000;
      else if (link.cmdValid && link.cmdOp == OP_RX_HOP) oscCal_q <= link.cmdCalCount;
   end

   assign baseWord = {intSet_q, fracHigh_q, fracMid_q, fracLow_q};

   // synthesizer outputs
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         freqWord_q <= 32'h00000000;
         outDiv_q <= DIV_BAND0;
         curChan_q <= CHAN_RESET;
      end else begin
         freqWord_q <= baseWord + 32'(chan_q) * 32'(step_q);
         curChan_q <= chan_q;
         case (band_q)
            2'h0: outDiv_q <= DIV_BAND0;
            2'h1: outDiv_q <= DIV_BAND1;
            2'h2: outDiv_q <= DIV_BAND2;
            default: outDiv_q <= DIV_BAND3;
         endcase
      end
   end

   // status and command completion
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rxOn_q <= 1'b0;
         txOn_q <= 1'b0;
         locked_q <= 1'b0;
         cmdDone_q <= 1'b0;
      end else begin
         rxOn_q <= state_q == ST_LISTEN || state_q == ST_LOCK || state_q == ST_SEARCH;
         txOn_q <= state_q == ST_TX;
         locked_q <= state_q == ST_LOCK;
         cmdDone_q <= link.cmdValid;
      end
   end
endmodule // schc_device
`default_nettype wire

// file: src/schc_host.sv
`timescale 1ns/1ps
`default_nettype none
module schc_host
   import schc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   schc_if.hst link,
   input wire logic reqValid,
   input wire schc_op_t reqOp,
   input wire logic [7:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic [7:0] reqChan,
   input wire logic reqHasChan,
   input wire logic [15:0] reqCalCount,
   output logic reqReady_q,
   output logic reqDone_q,
   output logic reqError_q
);
   logic [7:0] shadow [TABLE_MAX];
   logic [TABLE_MAX-1:0] usable_q;
   logic busy_q;
   logic valid_q;
   schc_op_t op_q;
   logic [7:0] addr_q, data_q, chan_q;
   logic hasChan_q;
   logic [15:0] cal_q;
   logic badFrac, isTbl;
   logic [5:0] firstIdx;
   logic anyUsable;

   assign link.cmdValid = valid_q;
   assign link.cmdOp = op_q;
   assign link.cmdAddr = addr_q;
   assign link.cmdData = data_q;
   assign link.cmdChan = chan_q;
   assign link.cmdHasChan = hasChan_q;
   assign link.cmdCalCount = cal_q;

   assign badFrac = reqOp == OP_SET_PROP && reqAddr == PROP_SYNTH_FRAC_HIGH
      && (reqData < FRAC_HIGH_MIN || reqData > FRAC_HIGH_MAX);
   assign isTbl = reqAddr >= PROP_TABLE_BASE && reqAddr < PROP_TABLE_BASE + 8'(TABLE_MAX);

   // lowest table entry not marked skip
   always_comb begin
      firstIdx = 6'h00;
      anyUsable = 1'b0;
      for (int i = TABLE_MAX - 1; i >= 0; i--) begin
         if (usable_q[i]) begin
            firstIdx = 6'(i);
            anyUsable = 1'b1;
         end
      end
   end

   // shadow of table writes
   always_ff @(posedge mclk) begin
      if (reqValid && reqReady_q && reqOp == OP_SET_PROP && isTbl) begin
         shadow[6'(reqAddr - PROP_TABLE_BASE)] <= reqData;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) usable_q <= '0;
      else if (reqValid && reqReady_q && reqOp == OP_SET_PROP && isTbl)
         usable_q[6'(reqAddr - PROP_TABLE_BASE)] <= reqData != SKIP_ENTRY;
   end

   // one command in flight, held until the device answers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         valid_q <= 1'b0;
         op_q <= OP_NONE;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         chan_q <= 8'h00;
         hasChan_q <= 1'b0;
         cal_q <= 16'h0000;
         reqReady_q <= 1'b1;
         reqDone_q <= 1'b0;
         reqError_q <= 1'b0;
      end else begin
         reqDone_q <= 1'b0;
         reqError_q <= 1'b0;
         valid_q <= 1'b0;
         if (busy_q) begin
            if (link.cmdDone) begin
               busy_q <= 1'b0;
               reqReady_q <= 1'b1;
               reqDone_q <= 1'b1;
            end
         end else if (reqValid && (badFrac || reqOp == OP_NONE)) begin
            reqError_q <= 1'b1;
         end else if (reqValid) begin
            busy_q <= 1'b1;
            reqReady_q <= 1'b0;
            valid_q <= 1'b1;
            addr_q <= reqAddr;
            data_q <= reqData;
            cal_q <= reqCalCount;
            if (reqOp == OP_START_AUTO) begin
               op_q <= OP_START_RX;
               chan_q <= shadow[firstIdx];
               hasChan_q <= anyUsable;
            end else begin
               op_q <= reqOp;
               chan_q <= reqChan;
               hasChan_q <= reqHasChan;
            end
         end
      end
   end
endmodule // schc_host
`default_nettype wire

// file: verification/schc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module schc_chk
   import schc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cmdValid,
   input wire schc_op_t cmdOp,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic [7:0] cmdChan,
   input wire logic cmdHasChan,
   input wire logic [15:0] cmdCalCount,
   input wire logic cmdDone
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // answer timing on the link
   property p_done_next;
      cmdValid |=> cmdDone;
   endproperty
   a_done_next: assert property (p_done_next)
      else $error("done missing after command");
   property p_done_cause;
      cmdDone |-> $past(cmdValid);
   endproperty
   a_done_cause: assert property (p_done_cause)
      else $error("done without command");
   property p_done_pulse;
      cmdDone |=> !cmdDone;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
   property p_cmd_spacing;
      cmdValid |=> !cmdValid [*2];
   endproperty
   a_cmd_spacing: assert property (p_cmd_spacing)
      else $error("commands too close");
   // content the host may send
   property p_frac_window;
      cmdValid && cmdOp == OP_SET_PROP && cmdAddr == PROP_SYNTH_FRAC_HIGH
         |-> cmdData >= FRAC_HIGH_MIN && cmdData <= FRAC_HIGH_MAX;
   endproperty
   a_frac_window: assert property (p_frac_window)
      else $error("fraction high outside window");
   property p_op_legal;
      cmdValid |-> cmdOp inside {OP_SET_PROP, OP_START_RX, OP_START_TX, OP_RX_HOP, OP_GO_IDLE};
   endproperty
   a_op_legal: assert property (p_op_legal)
      else $error("illegal opcode on link");
   property p_start_chan;
      cmdValid && cmdOp == OP_START_RX && cmdHasChan |-> cmdChan != SKIP_ENTRY;
   endproperty
   a_start_chan: assert property (p_start_chan)
      else $error("receive start on skip channel");
   property p_done_quiet;
      cmdDone |-> !cmdValid;
   endproperty
   a_done_quiet: assert property (p_done_quiet)
      else $error("command during done");
endmodule // schc_chk
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import schc_pkg::*;
   localparam int AUTO = 8;
   logic mclk, rstn, reqValid, reqHasChan, preambleBad, syncMissing, lastErr, prevGpio;
   logic reqReady, reqDone, reqError, rxOn, txOn, locked, hopGpio;
   schc_op_t reqOp;
   logic [7:0] reqAddr, reqData, reqChan, rssiNow, curChan, prevChan;
   logic [15:0] reqCalCount, oscCal;
   logic [31:0] freqWord;
   logic [4:0] outDiv;
   logic [4:0] divs[4] = '{5'h18, 5'h0C, 5'h08, 5'h04};
   logic [7:0] ents[4] = '{8'h03, 8'hFF, 8'h06, 8'hFF};
   logic [7:0] chanLog[$];
   int chanCyc[$];
   int fails, nChecks, cyc, gpioFlips, qs, n0;
   schc_if bus();
   schc_device #(.TABLE_DEPTH(TABLE_MAX), .AUTO_CYC(AUTO)) schc_device_i (
      .mclk(mclk), .rstn(rstn), .link(bus), .rssiNow(rssiNow), .preambleBad(preambleBad),
      .syncMissing(syncMissing), .freqWord_q(freqWord), .outDiv_q(outDiv), .curChan_q(curChan),
      .oscCal_q(oscCal), .rxOn_q(rxOn), .txOn_q(txOn), .locked_q(locked), .hopGpio_q(hopGpio));
   schc_host schc_host_i (
      .mclk(mclk), .rstn(rstn), .link(bus), .reqValid(reqValid), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqData(reqData), .reqChan(reqChan), .reqHasChan(reqHasChan),
      .reqCalCount(reqCalCount), .reqReady_q(reqReady), .reqDone_q(reqDone),
      .reqError_q(reqError));
   schc_chk schc_chk_i (
      .mclk(mclk), .rstn(rstn), .cmdValid(bus.cmdValid), .cmdOp(bus.cmdOp),
      .cmdAddr(bus.cmdAddr), .cmdData(bus.cmdData), .cmdChan(bus.cmdChan),
      .cmdHasChan(bus.cmdHasChan), .cmdCalCount(bus.cmdCalCount), .cmdDone(bus.cmdDone));
   // clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // one request on the user side, waits for the answer or refusal
   task automatic req(input schc_op_t op, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] ch, input logic hc, input logic [15:0] cal);
      int n;
      n = 0;
      while (reqReady !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 20) fails++;
      reqOp = op;
      reqAddr = a;
      reqData = d;
      reqChan = ch;
      reqHasChan = hc;
      reqCalCount = cal;
      reqValid = 1'b1;
      @(negedge mclk);
      reqValid = 1'b0;
      n = 0;
      while (reqDone !== 1'b1 && reqError !== 1'b1 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 20) fails++;
      lastErr = reqError;
   endtask
   task automatic setp(input logic [7:0] a, input logic [7:0] d);
      req(OP_SET_PROP, a, d, 8'h00, 1'b0, 16'h0000);
   endtask
   task automatic start(input schc_op_t op, input logic [7:0] ch, input logic hc);
      req(op, 8'h00, 8'h00, ch, hc, 16'h0000);
      repeat (AUTO + 4) @(negedge mclk);
   endtask
   // log channel changes and gpio flips, cut a hang short
   always @(negedge mclk) begin
      cyc++;
      if (rstn && curChan !== prevChan) begin
         chanLog.push_back(curChan);
         chanCyc.push_back(cyc);
      end
      if (rstn && hopGpio !== prevGpio)
         gpioFlips++;
      prevChan = curChan;
      prevGpio = hopGpio;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   // main sequence
   initial begin
      rstn = 1'b0;
      reqValid = 1'b0;
      reqOp = OP_NONE;
      reqAddr = 8'h00;
      reqData = 8'h00;
      reqChan = 8'h00;
      reqHasChan = 1'b0;
      reqCalCount = 16'h0000;
      rssiNow = 8'h10;
      preambleBad = 1'b0;
      syncMissing = 1'b0;
      repeat (10) @(negedge mclk);
      rstn = 1'b1;
      @(negedge mclk);
      chk(outDiv, 5'h18);
      chk(curChan, 8'h00);
      chk(freqWord, 32'h0008_0000);
      for (int b = 0; b < 4; b++) begin
         setp(PROP_BAND, 8'(b));
         @(negedge mclk);
         chk(outDiv, divs[b]);
      end
      $display("test band done");
      setp(PROP_SYNTH_INTEGER, 8'h20);
      setp(PROP_SYNTH_FRAC_HIGH, 8'h0F);
      chk(lastErr, 1'b0);
      setp(PROP_SYNTH_FRAC_HIGH, 8'h10);
      chk(lastErr, 1'b1);
      setp(PROP_SYNTH_FRAC_HIGH, 8'h0A);
      setp(PROP_SYNTH_FRAC_MID, 8'h12);
      setp(PROP_SYNTH_FRAC_LOW, 8'h34);
      setp(PROP_STEP_HIGH, 8'h01);
      setp(PROP_STEP_LOW, 8'h00);
      start(OP_START_RX, 8'h05, 1'b1);
      chk(curChan, 8'h05);
      chk(rxOn, 1'b1);
      chk(freqWord, 32'h200A_1234 + 32'h0000_0500);
      start(OP_GO_IDLE, 8'h00, 1'b0);
      start(OP_START_RX, 8'h09, 1'b0);
      chk(curChan, 8'h05);
      start(OP_START_TX, 8'h07, 1'b1);
      chk(txOn, 1'b1);
      chk(freqWord, 32'h200A_1234 + 32'h0000_0700);
      req(OP_NONE, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000);
      chk(lastErr, 1'b1);
      $display("test frequency done");
      for (int i = 0; i < 4; i++)
         setp(PROP_TABLE_BASE + 8'(i), ents[i]);
      setp(PROP_TABLE_SIZE, 8'h04);
      setp(PROP_LEVEL_THRESHOLD, 8'h80);
      setp(PROP_GPIO_CFG, 8'h01);
      setp(PROP_HOP_CONTROL, 8'h03);
      qs = chanLog.size();
      n0 = gpioFlips;
      req(OP_START_AUTO, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0000);
      repeat (100) @(negedge mclk);
      for (int i = 0; i < 4; i++)
         chk(chanLog[qs + i], (i % 2) ? 8'h06 : 8'h03);
      chk(chanCyc[qs + 2] - chanCyc[qs + 1] inside {[AUTO:2 * AUTO + 8]}, 1'b1);
      chk(gpioFlips - n0 >= 3, 1'b1);
      rssiNow = 8'hC0;
      repeat (40) @(negedge mclk);
      n0 = chanLog.size();
      repeat (30) @(negedge mclk);
      chk(chanLog.size(), n0);
      chk(locked, 1'b1);
      $display("test auto hop done");
      setp(PROP_HOP_CONTROL, 8'h15);
      preambleBad = 1'b1;
      start(OP_START_RX, 8'h03, 1'b1);
      n0 = chanLog.size();
      repeat (40) @(negedge mclk);
      chk(chanLog.size(), n0);
      setp(PROP_HOP_CONTROL, 8'h05);
      repeat (40) @(negedge mclk);
      chk(chanLog.size() > n0, 1'b1);
      preambleBad = 1'b0;
      syncMissing = 1'b1;
      setp(PROP_HOP_CONTROL, 8'h09);
      n0 = chanLog.size();
      repeat (40) @(negedge mclk);
      chk(chanLog.size() > n0, 1'b1);
      $display("test conditions done");
      setp(PROP_HOP_CONTROL, 8'h00);
      syncMissing = 1'b0;
      repeat (AUTO + 8) @(negedge mclk);
      req(OP_RX_HOP, 8'h00, 8'h00, 8'h21, 1'b1, 16'hBEEF);
      repeat (MAN_HOP_CYC - 10) @(negedge mclk);
      chk(rxOn, 1'b0);
      repeat (20) @(negedge mclk);
      chk(curChan, 8'h21);
      chk(oscCal, 16'hBEEF);
      chk(rxOn, 1'b1);
      $display("test manual hop done");
      complete_run();
   end
endmodule // testbench
`default_nettype wire
